// ===== pkg/tmc_pkg.sv
// Constants, types and counting helper for the timer0/1 and external interrupt control block.
// Assumes an 8-bit register port and one 25 MHz system clock.
// Function
// - Timer1's overflow flag is set on its overflow and cleared when the CPU acknowledges it.
// - Timer1 holds while its run bit is 0 and advances while it is 1.
// - Timer0's overflow flag is set on its overflow and cleared when the CPU acknowledges it.
// - Timer0 holds while its run bit is 0 and advances while it is 1.
// - Pin B's pending flag is set on each falling edge of that pin, enabled or not, and cleared on acknowledge.
// - Pin B requests on low level when its trigger select is 0 and on falling edges when it is 1.
// - Pin A's pending flag is set on each falling edge of that pin, enabled or not, and cleared on acknowledge.
// - Pin A requests on low level when its trigger select is 0 and on falling edges when it is 1.
// - With gating on, timer1 runs only while pin B is high and its run bit is set.
// - In timer mode, timer1 advances once every 2 system clocks.
// - In counter mode, timer1 advances on each falling edge of its count pin or of slow clock divided by SLOW_DIV (16 by default).
// - Timer1 mode 00 is 8 bits with 5-bit prescaler, 01 is 16 bits, 10 is 8-bit auto-reload, 11 stops it.
// - Timer0 has the same first three modes; in mode 11 its low byte counts alone and its high byte uses timer1's run bit and flag.
// - With gating on, timer0 runs only while pin A is high and its run bit is set.
// - Timer0 advances every 2 system clocks in timer mode and on count pin falling edges in counter mode.
package tmc_pkg;

  localparam logic [7:0] ADR_CTRL = 8'h88;
  localparam logic [7:0] ADR_MODE = 8'h89;
  localparam logic [7:0] ADR_TL0 = 8'h8A;
  localparam logic [7:0] ADR_TL1 = 8'h8B;
  localparam logic [7:0] ADR_TH0 = 8'h8C;
  localparam logic [7:0] ADR_TH1 = 8'h8D;
  localparam logic [7:0] ADR_IRQ_STAT = 8'hA0;
  localparam logic [7:0] ADR_IRQ_CLR = 8'hA1;
  localparam logic [7:0] ADR_IRQ_EN = 8'hA2;
  localparam logic [7:0] ADR_AUX = 8'hA3;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] PRESC_ONE = 5'h01;
  localparam logic [4:0] PRESC_MAX = 5'h1F;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  // Control register bit positions
  localparam int CB_T1_OVF = 7;
  localparam int CB_T1_RUN = 6;
  localparam int CB_T0_OVF = 5;
  localparam int CB_T0_RUN = 4;
  localparam int CB_EB_PEND = 3;
  localparam int CB_EB_TRIG = 2;
  localparam int CB_EA_PEND = 1;
  localparam int CB_EA_TRIG = 0;

  // Mode register bit positions
  localparam int MB_T1_GATE = 7;
  localparam int MB_T1_SRC = 6;
  localparam int MB_T1_MODE = 4;
  localparam int MB_T0_GATE = 3;
  localparam int MB_T0_SRC = 2;
  localparam int MB_T0_MODE = 0;

  localparam int AUX_T1_SLOW = 0;
  localparam int SLOW_DIV_DEF = 16;

  typedef enum logic [1:0] {TMC_M13, TMC_M16, TMC_M8RL, TMC_MSPLIT} tmc_mode_e;

  // One bit per interrupt source, in vector priority order
  typedef struct packed {
    logic t1;
    logic eb;
    logic t0;
    logic ea;
  } tmc_src_s;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } tmc_cnt_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] aux;
    logic div2;
    logic [7:0] slow_cnt;
    tmc_src_s stat;
    tmc_src_s en;
    tmc_src_s req;
    logic irq;
    logic [7:0] rdata;
  } tmc_state_s;

  localparam tmc_state_s STATE_RST = '0;

  // One count step of a timer pair in the given mode
  function automatic tmc_cnt_s tmc_step(input logic [7:0] lo, input logic [7:0] hi,
                                        input tmc_mode_e mode, input logic inc);
    tmc_cnt_s r;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    if (inc)
    begin
      case (mode)
        TMC_M13:
        begin
          r.lo[4:0] = lo[4:0] + PRESC_ONE;
          if (lo[4:0] == PRESC_MAX)
          begin
            r.hi = hi + BYTE_ONE;
            r.ovf = (hi == BYTE_MAX);
          end
        end
        TMC_M16:
        begin
          {r.hi, r.lo} = {hi, lo} + WORD_ONE;
          r.ovf = ({hi, lo} == WORD_MAX);
        end
        TMC_M8RL:
        begin
          r.lo = (lo == BYTE_MAX) ? hi : lo + BYTE_ONE;
          r.ovf = (lo == BYTE_MAX);
        end
        default:
        begin
          r.lo = lo + BYTE_ONE;
          r.ovf = (lo == BYTE_MAX);
        end
      endcase
    end
    return r;
  endfunction : tmc_step

endpackage : tmc_pkg

// ===== core/tmc_pin_sync.sv
// Two-stage synchroniser with falling edge detection for asynchronous pins.
// Assumes idle-high pins; stages reset high so release gives no false edge.
module tmc_pin_sync #(
  parameter int W = 5
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tmc_sync_s;

  tmc_sync_s st_r;
  tmc_sync_s st_nxt;

  if (W < 1)
  begin : g_chk
    $error("tmc_pin_sync: W must be at least 1");
  end

  always_comb
  begin
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st_r <= '1;
    else
      st_r <= st_nxt;
  end

  // First stage is read only by the second
  assign o_sync = st_r.s2;
  assign o_fall = st_r.s3 & ~st_r.s2;

  sync_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rst_n, 2) |-> o_sync == $past(i_async, 2))
    else $error("synchronised pin does not follow input by two cycles");

endmodule : tmc_pin_sync

// ===== core/tmc_timer_ctrl.sv
// Timer0/timer1 counting, control flags and external interrupt pin handling.
// Assumes a one-cycle register port, idle-high pins and a CPU acknowledge pulse per source.
//
// The address-and-strobe port was chosen for this implementation.
module tmc_timer_ctrl #(
  parameter int SLOW_DIV = tmc_pkg::SLOW_DIV_DEF
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_EXT_IRQ_A,
  input wire logic I_EXT_IRQ_B,
  input wire logic I_T0_COUNT,
  input wire logic I_T1_COUNT,
  input wire logic I_SLOW_CLK,
  input wire tmc_pkg::tmc_src_s I_VEC_ACK,
  output tmc_pkg::tmc_src_s O_IRQ_REQ,
  output logic O_IRQ
);

  localparam logic [7:0] SLOW_LAST = 8'(SLOW_DIV - 1);

  if (SLOW_DIV < 2 || SLOW_DIV > 256)
  begin : g_chk
    $error("tmc_timer_ctrl: SLOW_DIV must be 2..256");
  end

  tmc_pkg::tmc_state_s st_r;
  tmc_pkg::tmc_state_s st_nxt;

  logic [4:0] pin_sync;
  logic [4:0] pin_fall;

  tmc_pin_sync #(
    .W(5)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_SLOW_CLK, I_T1_COUNT, I_T0_COUNT, I_EXT_IRQ_B, I_EXT_IRQ_A}),
    .o_sync(pin_sync),
    .o_fall(pin_fall)
  );

  logic pin_a;
  logic pin_b;
  logic fall_a;
  logic fall_b;
  logic fall_t0;
  logic fall_t1;
  logic fall_slow;
  assign pin_a = pin_sync[0];
  assign pin_b = pin_sync[1];
  assign fall_a = pin_fall[0];
  assign fall_b = pin_fall[1];
  assign fall_t0 = pin_fall[2];
  assign fall_t1 = pin_fall[3];
  assign fall_slow = pin_fall[4];

  tmc_pkg::tmc_mode_e m0;
  tmc_pkg::tmc_mode_e m1;
  logic split;
  logic tick2;
  logic slow16;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic inc_th0;
  tmc_pkg::tmc_cnt_s s0;
  tmc_pkg::tmc_cnt_s s1;
  tmc_pkg::tmc_cnt_s sh;
  logic ovf0;
  logic ovf1;

  assign m0 = tmc_pkg::tmc_mode_e'(st_r.mode[tmc_pkg::MB_T0_MODE +: 2]);
  assign m1 = tmc_pkg::tmc_mode_e'(st_r.mode[tmc_pkg::MB_T1_MODE +: 2]);
  assign split = (m0 == tmc_pkg::TMC_MSPLIT);
  // Half-rate tick shared by both timers in timer mode
  assign tick2 = st_r.div2;
  assign slow16 = fall_slow && (st_r.slow_cnt == SLOW_LAST);

  assign run0 = st_r.ctrl[tmc_pkg::CB_T0_RUN]
    && (!st_r.mode[tmc_pkg::MB_T0_GATE] || pin_a);
  assign run1 = st_r.ctrl[tmc_pkg::CB_T1_RUN]
    && (!st_r.mode[tmc_pkg::MB_T1_GATE] || pin_b);
  assign inc0 = run0 && (st_r.mode[tmc_pkg::MB_T0_SRC] ? fall_t0 : tick2);
  assign inc1 = run1 && (m1 != tmc_pkg::TMC_MSPLIT)
    && (st_r.mode[tmc_pkg::MB_T1_SRC]
        ? (st_r.aux[tmc_pkg::AUX_T1_SLOW] ? slow16 : fall_t1) : tick2);
  // Split mode high byte borrows timer1's run bit and is timer-only
  assign inc_th0 = split && st_r.ctrl[tmc_pkg::CB_T1_RUN] && tick2;

  assign s0 = tmc_pkg::tmc_step(st_r.tl0, st_r.th0, m0, inc0);
  assign s1 = tmc_pkg::tmc_step(st_r.tl1, st_r.th1, m1, inc1);
  assign sh = tmc_pkg::tmc_step(st_r.th0, tmc_pkg::BYTE_ZERO, tmc_pkg::TMC_MSPLIT, inc_th0);
  assign ovf0 = s0.ovf;
  // Timer1 loses its flag to timer0's high byte while timer0 is split
  assign ovf1 = split ? sh.ovf : s1.ovf;

  logic wr_ctrl;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;
  assign wr_ctrl = I_WR && (I_ADDR == tmc_pkg::ADR_CTRL);
  assign wr_tl0 = I_WR && (I_ADDR == tmc_pkg::ADR_TL0);
  assign wr_th0 = I_WR && (I_ADDR == tmc_pkg::ADR_TH0);
  assign wr_tl1 = I_WR && (I_ADDR == tmc_pkg::ADR_TL1);
  assign wr_th1 = I_WR && (I_ADDR == tmc_pkg::ADR_TH1);

  always_comb
  begin
    logic [7:0] base;
    logic [3:0] clr;
    base = wr_ctrl ? I_WDATA : st_r.ctrl;
    clr = 4'h0;
    st_nxt = st_r;
    st_nxt.rdata = tmc_pkg::BYTE_ZERO;
    st_nxt.div2 = !st_r.div2;
    if (fall_slow)
      st_nxt.slow_cnt = (st_r.slow_cnt == SLOW_LAST) ? tmc_pkg::BYTE_ZERO
        : st_r.slow_cnt + tmc_pkg::BYTE_ONE;

    // Software writes to the data bytes win over counting
    st_nxt.tl0 = wr_tl0 ? I_WDATA : s0.lo;
    st_nxt.th0 = wr_th0 ? I_WDATA : (split ? sh.lo : s0.hi);
    st_nxt.tl1 = wr_tl1 ? I_WDATA : s1.lo;
    st_nxt.th1 = wr_th1 ? I_WDATA : s1.hi;

    // Hardware set wins over software write and acknowledge
    st_nxt.ctrl = base;
    st_nxt.ctrl[tmc_pkg::CB_T1_OVF] = ovf1
      || (base[tmc_pkg::CB_T1_OVF] && !I_VEC_ACK.t1);
    st_nxt.ctrl[tmc_pkg::CB_T0_OVF] = ovf0
      || (base[tmc_pkg::CB_T0_OVF] && !I_VEC_ACK.t0);
    st_nxt.ctrl[tmc_pkg::CB_EB_PEND] = fall_b
      || (base[tmc_pkg::CB_EB_PEND] && !I_VEC_ACK.eb);
    st_nxt.ctrl[tmc_pkg::CB_EA_PEND] = fall_a
      || (base[tmc_pkg::CB_EA_PEND] && !I_VEC_ACK.ea);

    st_nxt.req.t1 = st_nxt.ctrl[tmc_pkg::CB_T1_OVF];
    st_nxt.req.t0 = st_nxt.ctrl[tmc_pkg::CB_T0_OVF];
    st_nxt.req.eb = st_r.ctrl[tmc_pkg::CB_EB_TRIG]
      ? st_nxt.ctrl[tmc_pkg::CB_EB_PEND] : !pin_b;
    st_nxt.req.ea = st_r.ctrl[tmc_pkg::CB_EA_TRIG]
      ? st_nxt.ctrl[tmc_pkg::CB_EA_PEND] : !pin_a;

    if (I_WR)
    begin
      if (I_ADDR == tmc_pkg::ADR_MODE)
        st_nxt.mode = I_WDATA;
      else if (I_ADDR == tmc_pkg::ADR_IRQ_CLR)
        clr = I_WDATA[3:0];
      else if (I_ADDR == tmc_pkg::ADR_IRQ_EN)
        st_nxt.en = tmc_pkg::tmc_src_s'(I_WDATA[3:0]);
      else if (I_ADDR == tmc_pkg::ADR_AUX)
        st_nxt.aux = I_WDATA;
    end
    st_nxt.stat = tmc_pkg::tmc_src_s'({ovf1, fall_b, ovf0, fall_a} | (st_r.stat & ~clr));
    st_nxt.irq = |(st_nxt.stat & st_nxt.en);

    if (I_RD)
    begin
      if (I_ADDR == tmc_pkg::ADR_CTRL)
        st_nxt.rdata = st_r.ctrl;
      else if (I_ADDR == tmc_pkg::ADR_MODE)
        st_nxt.rdata = st_r.mode;
      else if (I_ADDR == tmc_pkg::ADR_TL0)
        st_nxt.rdata = st_r.tl0;
      else if (I_ADDR == tmc_pkg::ADR_TL1)
        st_nxt.rdata = st_r.tl1;
      else if (I_ADDR == tmc_pkg::ADR_TH0)
        st_nxt.rdata = st_r.th0;
      else if (I_ADDR == tmc_pkg::ADR_TH1)
        st_nxt.rdata = st_r.th1;
      else if (I_ADDR == tmc_pkg::ADR_IRQ_STAT)
        st_nxt.rdata = {4'h0, st_r.stat};
      else if (I_ADDR == tmc_pkg::ADR_IRQ_EN)
        st_nxt.rdata = {4'h0, st_r.en};
      else if (I_ADDR == tmc_pkg::ADR_AUX)
        st_nxt.rdata = st_r.aux;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      st_r <= tmc_pkg::STATE_RST;
    else
      st_r <= st_nxt;
  end

  assign O_RDATA = st_r.rdata;
  assign O_IRQ_REQ = st_r.req;
  assign O_IRQ = st_r.irq;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  logic [15:0] t0v;
  logic [15:0] t1v;
  logic no_wr;
  assign t0v = {st_r.th0, st_r.tl0};
  assign t1v = {st_r.th1, st_r.tl1};
  assign no_wr = !I_WR;

  sequence t1_free_s;
    no_wr && run1 && !st_r.mode[tmc_pkg::MB_T1_SRC] && m1 == tmc_pkg::TMC_M16;
  endsequence
  sequence t0_free_s;
    no_wr && run0 && !st_r.mode[tmc_pkg::MB_T0_SRC] && m0 == tmc_pkg::TMC_M16;
  endsequence

  t1_flag_set_a: assert property (ovf1 |=> st_r.ctrl[tmc_pkg::CB_T1_OVF])
    else $error("timer1 overflow did not set its flag");
  t1_flag_ack_a: assert property (I_VEC_ACK.t1 && !ovf1 && !wr_ctrl
    |=> !st_r.ctrl[tmc_pkg::CB_T1_OVF] && !O_IRQ_REQ.t1)
    else $error("acknowledge did not clear timer1 flag");
  t1_halt_a: assert property (!st_r.ctrl[tmc_pkg::CB_T1_RUN] && no_wr |=> $stable(t1v))
    else $error("timer1 moved while halted");
  t0_flag_set_a: assert property (ovf0 |=> st_r.ctrl[tmc_pkg::CB_T0_OVF] && O_IRQ_REQ.t0)
    else $error("timer0 overflow did not set its flag");
  t0_halt_a: assert property (!st_r.ctrl[tmc_pkg::CB_T0_RUN] && no_wr |=> $stable(st_r.tl0))
    else $error("timer0 moved while halted");
  eb_edge_a: assert property (fall_b |=> st_r.ctrl[tmc_pkg::CB_EB_PEND])
    else $error("pin B falling edge lost");
  // Request is built from last cycle's trigger select, so both cycles must be level mode
  eb_level_a: assert property (!st_r.ctrl[tmc_pkg::CB_EB_TRIG] && no_wr
    && !$past(st_r.ctrl[tmc_pkg::CB_EB_TRIG])
    |-> (O_IRQ_REQ.eb == !$past(pin_b)) or $past(!I_RST_N))
    else $error("pin B level request wrong");
  ea_edge_a: assert property (fall_a |=> st_r.ctrl[tmc_pkg::CB_EA_PEND])
    else $error("pin A falling edge lost");
  ea_level_a: assert property (!st_r.ctrl[tmc_pkg::CB_EA_TRIG] && !pin_a |=> O_IRQ_REQ.ea)
    else $error("pin A low level gave no request");
  t1_gate_a: assert property (st_r.mode[tmc_pkg::MB_T1_GATE] && !pin_b && no_wr
    |=> $stable(t1v))
    else $error("timer1 ran while gated off");
  t1_rate_a: assert property (t1_free_s [*2] |=> t1v == $past(t1v, 2) + tmc_pkg::WORD_ONE)
    else $error("timer1 timer rate is not one per two clocks");
  t1_count_a: assert property (no_wr && run1 && st_r.mode[tmc_pkg::MB_T1_SRC]
    && !st_r.aux[tmc_pkg::AUX_T1_SLOW] && m1 == tmc_pkg::TMC_M16 && fall_t1
    |=> t1v == $past(t1v) + tmc_pkg::WORD_ONE)
    else $error("timer1 missed a count pin edge");
  t1_reload_a: assert property (no_wr && inc1 && m1 == tmc_pkg::TMC_M8RL
    && st_r.tl1 == tmc_pkg::BYTE_MAX |=> st_r.tl1 == $past(st_r.th1))
    else $error("timer1 auto-reload failed");
  t1_stop_a: assert property (m1 == tmc_pkg::TMC_MSPLIT && no_wr |=> $stable(t1v))
    else $error("timer1 counted in stop mode");
  t0_split_a: assert property (split && !st_r.ctrl[tmc_pkg::CB_T1_RUN] && no_wr
    |=> $stable(st_r.th0))
    else $error("split high byte ran without timer1 run bit");
  // Split high byte follows timer1's run bit, not timer0's gate
  t0_gate_a: assert property (st_r.mode[tmc_pkg::MB_T0_GATE] && !pin_a && no_wr && !split
    |=> $stable(t0v))
    else $error("timer0 ran while gated off");
  t0_rate_a: assert property (t0_free_s [*2] |=> t0v == $past(t0v, 2) + tmc_pkg::WORD_ONE)
    else $error("timer0 timer rate is not one per two clocks");

endmodule : tmc_timer_ctrl

// ===== verif/tmc_pin_model.sv
// Far-side model: interrupt pins, count pins and slow clock, all idle high.
// Assumes the bench calls its tasks from one process at a time.
module tmc_pin_model (
  input wire logic i_clk,
  output logic [4:0] o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line order: pin A, pin B, count0, count1, slow clock
  initial o_line = 5'h1F;

  task automatic drive(input int i, input logic v);
    @(posedge i_clk);
    o_line[i] <= v;
  endtask : drive

  // Three clocks low, three high, so the two-flop sampler never misses one
  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      drive(i, 1'b0);
      repeat (2) @(posedge i_clk);
      drive(i, 1'b1);
      repeat (2) @(posedge i_clk);
    end
  endtask : pulse
endmodule : tmc_pin_model

// ===== verif/tb_top.sv
// Self-checking bench for the timer and external interrupt control block.
// Assumes the pin model on the far side and a small slow clock divider.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [7:0] I_WDATA = 8'h00;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [7:0] O_RDATA;
  logic [4:0] line;
  tmc_pkg::tmc_src_s I_VEC_ACK = '0;
  tmc_pkg::tmc_src_s O_IRQ_REQ;
  logic O_IRQ;
  int bad_count = 0;
  int checks = 0;

  always #20 I_CLK = ~I_CLK;

  tmc_pin_model pm (.i_clk(I_CLK), .o_line(line));

  tmc_timer_ctrl #(.SLOW_DIV(2)) DUT (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_EXT_IRQ_A(line[0]),
    .I_EXT_IRQ_B(line[1]), .I_T0_COUNT(line[2]), .I_T1_COUNT(line[3]),
    .I_SLOW_CLK(line[4]), .I_VEC_ACK(I_VEC_ACK), .O_IRQ_REQ(O_IRQ_REQ), .O_IRQ(O_IRQ)
  );

  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, exp);
  endtask : rc

  task automatic ack(input logic [3:0] v);
    @(posedge I_CLK);
    I_VEC_ACK <= v;
    @(posedge I_CLK);
    I_VEC_ACK <= '0;
    #1;
  endtask : ack

  task automatic req_is(input logic [3:0] v, input logic e);
    chk({7'h00, |(O_IRQ_REQ & v)}, {7'h00, e});
  endtask : req_is

  // Reference counter: returns {ovf, hi, lo} after n steps
  function automatic int mdl(input int m, input int lo, input int hi, input int n);
    int ovf;
    int w;
    ovf = 0;
    repeat (n)
    begin
      case (m)
        0:
        begin
          w = (lo % 32) + 1;
          if (w == 32)
          begin
            w = 0;
            hi = hi + 1;
            if (hi == 256)
            begin
              hi = 0;
              ovf = 1;
            end
          end
          lo = lo - (lo % 32) + w;
        end
        1:
        begin
          w = hi * 256 + lo + 1;
          if (w == 65536)
          begin
            w = 0;
            ovf = 1;
          end
          hi = w / 256;
          lo = w % 256;
        end
        2:
        begin
          lo = lo + 1;
          if (lo == 256)
          begin
            lo = hi;
            ovf = 1;
          end
        end
        default:
        begin
          lo = lo + 1;
          if (lo == 256)
          begin
            lo = 0;
            ovf = 1;
          end
        end
      endcase
    end
    return ovf * 65536 + hi * 256 + lo;
  endfunction : mdl

  // p=0: pin A with timer0, p=1: pin B with timer1
  task automatic gate_pin(input int p);
    logic [7:0] run;
    logic [7:0] pend;
    logic [7:0] trig;
    logic [3:0] v;
    run = p ? 8'h40 : 8'h10;
    pend = p ? 8'h08 : 8'h02;
    trig = p ? 8'h04 : 8'h01;
    v = p ? 4'h4 : 4'h1;
    wr(tmc_pkg::ADR_MODE, p ? 8'hD0 : 8'h0D);
    wr(p ? tmc_pkg::ADR_TL1 : tmc_pkg::ADR_TL0, 8'h00);
    wr(tmc_pkg::ADR_CTRL, run | trig);
    pm.drive(p, 1'b0);
    pm.pulse(p + 2, 3);
    pm.drive(p, 1'b1);
    pm.pulse(p + 2, 2);
    if (p == 1)
    begin
      wr(tmc_pkg::ADR_AUX, 8'h01);
      pm.pulse(4, 4);
    end
    rc(p ? tmc_pkg::ADR_TL1 : tmc_pkg::ADR_TL0, p ? 8'h04 : 8'h02);
    rc(tmc_pkg::ADR_CTRL, run | trig | pend);
    ack(v);
    rc(tmc_pkg::ADR_CTRL, run | trig);
    wr(tmc_pkg::ADR_CTRL, 8'h00);
    pm.drive(p, 1'b0);
    cyc(5);
    req_is(v, 1'b1);
    ack(v);
    cyc(1);
    req_is(v, 1'b1);
    pm.drive(p, 1'b1);
    cyc(5);
    req_is(v, 1'b0);
    wr(tmc_pkg::ADR_CTRL, trig);
    pm.pulse(p, 1);
    #1;
    req_is(v, 1'b1);
    ack(v);
    req_is(v, 1'b0);
    wr(tmc_pkg::ADR_CTRL, 8'h00);
    wr(tmc_pkg::ADR_AUX, 8'h00);
  endtask : gate_pin

  initial
  begin
    logic [7:0] d;
    int m;
    int lo;
    int hi;
    int n;
    int e;
    int k;
    void'($urandom(32'h8B905474));
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rc(tmc_pkg::ADR_CTRL, 8'h00);
    rc(tmc_pkg::ADR_MODE, 8'h00);
    rc(8'h55, 8'h00);
    d = 8'($urandom);
    wr(tmc_pkg::ADR_MODE, d);
    rc(tmc_pkg::ADR_MODE, d);
    wr(tmc_pkg::ADR_IRQ_STAT, 8'hFF);
    rc(tmc_pkg::ADR_IRQ_STAT, 8'h00);
    rc(tmc_pkg::ADR_IRQ_CLR, 8'h00);
    // Timer1, 16 bits, 16 steps short of wrap
    wr(tmc_pkg::ADR_MODE, 8'h10);
    wr(tmc_pkg::ADR_TH1, 8'hFF);
    wr(tmc_pkg::ADR_TL1, 8'hF0);
    wr(tmc_pkg::ADR_IRQ_EN, 8'h08);
    wr(tmc_pkg::ADR_CTRL, 8'h40);
    k = 0;
    while (O_IRQ_REQ.t1 !== 1'b1 && k < 40)
    begin
      @(posedge I_CLK);
      #1;
      k++;
    end
    chk({7'h00, k >= 30 && k <= 34}, 8'h01);
    chk({7'h00, O_IRQ}, 8'h01);
    wr(tmc_pkg::ADR_CTRL, 8'h80);
    rc(tmc_pkg::ADR_CTRL, 8'h80);
    ack(4'h8);
    chk({4'h0, O_IRQ_REQ}, 8'h00);
    rc(tmc_pkg::ADR_CTRL, 8'h00);
    rc(tmc_pkg::ADR_IRQ_STAT, 8'h08);
    chk({7'h00, O_IRQ}, 8'h01);
    wr(tmc_pkg::ADR_IRQ_CLR, 8'h08);
    cyc(1);
    chk({7'h00, O_IRQ}, 8'h00);
    // Stopped timer must hold
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= tmc_pkg::ADR_TL1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    d = O_RDATA;
    cyc(10);
    rc(tmc_pkg::ADR_TL1, d);
    // Timer0 counter mode through every mode field value
    for (m = 0; m < 4; m++)
    begin
      lo = $urandom_range(255, 248);
      hi = (m == 2) ? $urandom_range(255, 0) : 255;
      n = $urandom_range(8, 1);
      e = mdl(m, lo, hi, n);
      wr(tmc_pkg::ADR_MODE, 8'h04 | 8'(m));
      wr(tmc_pkg::ADR_TL0, 8'(lo));
      wr(tmc_pkg::ADR_TH0, 8'(hi));
      wr(tmc_pkg::ADR_CTRL, 8'h10);
      pm.pulse(2, n);
      cyc(3);
      rc(tmc_pkg::ADR_CTRL, (e >= 65536) ? 8'h30 : 8'h10);
      rc(tmc_pkg::ADR_IRQ_STAT, (e >= 65536) ? 8'h02 : 8'h00);
      wr(tmc_pkg::ADR_IRQ_CLR, 8'h0F);
      if (e >= 65536)
      begin
        ack(4'h2);
        chk({4'h0, O_IRQ_REQ}, 8'h00);
      end
      wr(tmc_pkg::ADR_CTRL, 8'h00);
      rc(tmc_pkg::ADR_TL0, 8'(e));
      rc(tmc_pkg::ADR_TH0, 8'(e >> 8));
    end
    gate_pin(0);
    rc(tmc_pkg::ADR_IRQ_STAT, 8'h01);
    chk({7'h00, O_IRQ}, 8'h00);
    wr(tmc_pkg::ADR_IRQ_EN, 8'h01);
    cyc(1);
    chk({7'h00, O_IRQ}, 8'h01);
    wr(tmc_pkg::ADR_IRQ_CLR, 8'h0F);
    wr(tmc_pkg::ADR_IRQ_EN, 8'h00);
    gate_pin(1);
    rc(tmc_pkg::ADR_IRQ_STAT, 8'h04);
    finish_test();
  end

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge I_CLK);
    bad_count++;
    finish_test();
  end
endmodule : tb_top
